/* rtl/ftx_trigger_ctrl.sv */
// ftx_trigger_ctrl: hardware frame start trigger and exposure control.
// assumes bus inputs are synchronous to ref_clk; trigger lines may be asynchronous.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - enabled gate with line source triggers frames
// - polarity picks rising or falling trigger edge
// - selected edge while waiting starts acquisition
// - leave waiting on accepted trigger (delay or exposure), return when ready
// - one frame per accepted trigger edge
// - edges outside waiting state are discarded
// - two exposure modes: timed and pulse width
// - timed exposure lasts programmed duration
// - timed overlap edge ignored, overtrigger event raised
// - width rising: expose while input high
// - width mode still waits programmed duration
// - programmable microsecond delay before trigger acts
// - delay bypassed for gate off or host
// - source defaults to first input line
// - host trigger always uses timed exposure
module ftx_trigger_ctrl (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [1:0] ext_frame_trigger_in,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic exposure_active,
    output logic waiting_for_trigger,
    output logic frame_start,
    output logic irq
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old,
            input logic [31:0] val, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = val[8*i +: 8];
            end
        end
        return res;
    endfunction : merge

    function automatic logic mapped(input logic [7:0] a);
        return a == ftx_pkg::OFS_CTRL || a == ftx_pkg::OFS_EXPO ||
            a == ftx_pkg::OFS_DELAY || a == ftx_pkg::OFS_CMD ||
            a == ftx_pkg::OFS_STATUS || a == ftx_pkg::OFS_IRQ_STAT ||
            a == ftx_pkg::OFS_IRQ_MASK;
    endfunction : mapped

    logic aw_have, w_have, wr_do;
    logic [7:0] waddr;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [4:0] ctrl;
    logic [23:0] exposure_duration_us, trigger_delay_us;
    logic [2:0] irq_stat, irq_mask, irq_set, next_irq_stat;
    logic host_trigger_command;
    ftx_pkg::ftx_state_type state, next_state;
    logic [1:0] sync1, sync2, prev;
    logic [1:0] src;
    logic level, prv, act, prev_act, hw_mode, hw_edge, sw_go;
    logic pulse_width_exposure;
    logic [6:0] presc;
    logic tick, tmr_end, load_tmr, start;
    logic [23:0] tmr;
    logic [31:0] rd_mux;

    // ------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------
    // one write in flight; address and data taken in either order
    assign wr_do = aw_have && w_have && !s_axi_bvalid;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ftx_pkg::RESP_OKAY;
            aw_have <= 1'b0;
            w_have <= 1'b0;
            waddr <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                aw_have <= 1'b1;
                waddr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                w_have <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_do) begin
                aw_have <= 1'b0;
                w_have <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(waddr) ? ftx_pkg::RESP_OKAY :
                    ftx_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl <= ftx_pkg::CTRL_RESET;
            exposure_duration_us <= ftx_pkg::EXPO_RESET;
            trigger_delay_us <= ftx_pkg::DELAY_RESET;
            irq_mask <= ftx_pkg::IRQ_RESET;
        end else if (wr_do) begin
            case (waddr)
                ftx_pkg::OFS_CTRL: begin
                    ctrl <= 5'(merge(32'(ctrl), wdata_q, wstrb_q));
                end
                ftx_pkg::OFS_EXPO: begin
                    exposure_duration_us <= 24'(merge(
                        32'(exposure_duration_us), wdata_q, wstrb_q));
                end
                ftx_pkg::OFS_DELAY: begin
                    trigger_delay_us <= 24'(merge(32'(trigger_delay_us),
                        wdata_q, wstrb_q));
                end
                ftx_pkg::OFS_IRQ_MASK: begin
                    irq_mask <= 3'(merge(32'(irq_mask), wdata_q, wstrb_q));
                end
                default: begin
                end
            endcase
        end
    end

    assign host_trigger_command = wr_do && waddr == ftx_pkg::OFS_CMD &&
        wstrb_q[0] && wdata_q[0];

    // ------------------------------------------------------------
    // trigger input
    // ------------------------------------------------------------
    // two-stage synchroniser
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1 <= 2'h0;
            sync2 <= 2'h0;
            prev <= 2'h0;
        end else begin
            sync1 <= ext_frame_trigger_in;
            sync2 <= sync1;
            prev <= sync2;
        end
    end

    // switching source or polarity fakes no edge; both samples use the same setting
    assign src = ctrl[ftx_pkg::CTRL_SRC_HI:ftx_pkg::CTRL_SRC_LO];
    assign level = sync2[src == ftx_pkg::SRC_LINE2];
    assign prv = prev[src == ftx_pkg::SRC_LINE2];
    assign act = ctrl[ftx_pkg::CTRL_POL] ? !level : level;
    assign prev_act = ctrl[ftx_pkg::CTRL_POL] ? !prv : prv;
    assign hw_mode = ctrl[ftx_pkg::CTRL_GATE] && src != ftx_pkg::SRC_HOST;
    assign hw_edge = hw_mode && act && !prev_act;
    assign sw_go = host_trigger_command && !hw_mode;
    assign pulse_width_exposure = hw_mode && ctrl[ftx_pkg::CTRL_KIND];

    // ------------------------------------------------------------
    // microsecond timer
    // ------------------------------------------------------------
    // prescaler restarts on each load so every interval is whole us
    assign tick = presc == 7'(ftx_pkg::CYC_PER_US - 1);
    assign tmr_end = tick && tmr == 24'h000001;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            presc <= 7'h00;
            tmr <= 24'h000000;
        end else if (load_tmr) begin
            presc <= 7'h00;
            if (next_state == ftx_pkg::ST_DELAY) begin
                tmr <= trigger_delay_us;
            end else begin
                // minimum time kept in width mode
                tmr <= exposure_duration_us == 24'h000000 ? 24'h000001 :
                    exposure_duration_us;
            end
        end else begin
            presc <= tick ? 7'h00 : presc + 7'h01;
            if (tick && tmr != 24'h000000) begin
                tmr <= tmr - 24'h000001;
            end
        end
    end

    // ------------------------------------------------------------
    // acquisition state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            ftx_pkg::ST_WAIT: begin
                if (hw_edge) begin
                    if (trigger_delay_us != 24'h000000) begin
                        next_state = ftx_pkg::ST_DELAY;
                    end else if (pulse_width_exposure) begin
                        next_state = ftx_pkg::ST_WIDTH;
                    end else begin
                        next_state = ftx_pkg::ST_TIMED;
                    end
                end else if (sw_go) begin
                    next_state = ftx_pkg::ST_TIMED;
                end
            end
            ftx_pkg::ST_DELAY: begin
                if (tmr_end) begin
                    next_state = pulse_width_exposure ?
                        ftx_pkg::ST_WIDTH : ftx_pkg::ST_TIMED;
                end
            end
            ftx_pkg::ST_TIMED: begin
                if (tmr_end) begin
                    next_state = ftx_pkg::ST_WAIT;
                end
            end
            ftx_pkg::ST_WIDTH: begin
                if (!act) begin
                    next_state = tmr == 24'h000000 ? ftx_pkg::ST_WAIT :
                        ftx_pkg::ST_HOLD;
                end
            end
            ftx_pkg::ST_HOLD: begin
                if (tmr == 24'h000000) begin
                    next_state = ftx_pkg::ST_WAIT;
                end
            end
            default: begin
                next_state = ftx_pkg::ST_WAIT;
            end
        endcase
    end

    assign load_tmr = next_state != state && (next_state ==
        ftx_pkg::ST_DELAY || next_state == ftx_pkg::ST_TIMED ||
        next_state == ftx_pkg::ST_WIDTH);
    assign start = load_tmr && next_state != ftx_pkg::ST_DELAY;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= ftx_pkg::ST_WAIT;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // events and outputs
    // ------------------------------------------------------------
    always_comb begin
        irq_set = 3'h0;
        // late edge dropped, flagged if timed
        irq_set[ftx_pkg::IRQ_OVER] = hw_edge &&
            state != ftx_pkg::ST_WAIT && !pulse_width_exposure;
        irq_set[ftx_pkg::IRQ_START] = start;
        irq_set[ftx_pkg::IRQ_END] = (state == ftx_pkg::ST_TIMED ||
            state == ftx_pkg::ST_WIDTH) && next_state != state;
        next_irq_stat = irq_stat | irq_set;
        // set wins over a write-one clear in the same cycle
        if (wr_do && waddr == ftx_pkg::OFS_IRQ_STAT && wstrb_q[0]) begin
            next_irq_stat = (irq_stat & ~wdata_q[2:0]) | irq_set;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_stat <= ftx_pkg::IRQ_RESET;
            irq <= 1'b0;
            exposure_active <= 1'b0;
            waiting_for_trigger <= 1'b1;
            frame_start <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            irq <= |(next_irq_stat & irq_mask);
            exposure_active <= next_state == ftx_pkg::ST_TIMED ||
                next_state == ftx_pkg::ST_WIDTH;
            waiting_for_trigger <= next_state == ftx_pkg::ST_WAIT;
            frame_start <= start;
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------
    always_comb begin
        case (s_axi_araddr)
            ftx_pkg::OFS_CTRL: rd_mux = 32'(ctrl);
            ftx_pkg::OFS_EXPO: rd_mux = 32'(exposure_duration_us);
            ftx_pkg::OFS_DELAY: rd_mux = 32'(trigger_delay_us);
            ftx_pkg::OFS_STATUS: rd_mux = {28'h0000000,
                state == ftx_pkg::ST_HOLD, state == ftx_pkg::ST_DELAY,
                exposure_active, waiting_for_trigger};
            ftx_pkg::OFS_IRQ_STAT: rd_mux = 32'(irq_stat);
            ftx_pkg::OFS_IRQ_MASK: rd_mux = 32'(irq_mask);
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= ftx_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= mapped(s_axi_araddr) ? ftx_pkg::RESP_OKAY :
                ftx_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_edge_waiting;
        hw_edge && state == ftx_pkg::ST_WAIT;
    endsequence

    sequence s_left_waiting;
        ##1 state != ftx_pkg::ST_WAIT ##1 !waiting_for_trigger;
    endsequence

    property p_edge_starts;
        @(posedge ref_clk) disable iff (!rst_b)
        s_edge_waiting |-> s_left_waiting;
    endproperty
    a_edge_starts: assert property (p_edge_starts)
        else $error("accepted edge did not leave waiting");

    property p_overtrigger;
        @(posedge ref_clk) disable iff (!rst_b)
        (hw_edge && state != ftx_pkg::ST_WAIT && !pulse_width_exposure)
            |=> irq_stat[ftx_pkg::IRQ_OVER] &&
            ($stable(state) || $past(tmr_end));
    endproperty
    a_overtrigger: assert property (p_overtrigger)
        else $error("overtrigger not flagged or not ignored");

    property p_timed_end;
        @(posedge ref_clk) disable iff (!rst_b)
        (state == ftx_pkg::ST_TIMED && tmr_end)
            |=> !exposure_active ##0 waiting_for_trigger;
    endproperty
    a_timed_end: assert property (p_timed_end)
        else $error("timed exposure did not end on time");

    property p_width_end;
        @(posedge ref_clk) disable iff (!rst_b)
        (state == ftx_pkg::ST_WIDTH && !act) |=> !exposure_active;
    endproperty
    a_width_end: assert property (p_width_end)
        else $error("width exposure outlived active level");

    property p_host_timed;
        @(posedge ref_clk) disable iff (!rst_b)
        (sw_go && state == ftx_pkg::ST_WAIT)
            |=> state == ftx_pkg::ST_TIMED ##1 frame_start == 1'b0;
    endproperty
    a_host_timed: assert property (p_host_timed)
        else $error("host trigger not timed or delayed");

    property p_delay_used;
        @(posedge ref_clk) disable iff (!rst_b)
        (s_edge_waiting ##0 trigger_delay_us != 24'h000000)
            |=> state == ftx_pkg::ST_DELAY ##1 !exposure_active;
    endproperty
    a_delay_used: assert property (p_delay_used)
        else $error("trigger delay skipped");

    property p_hold_min;
        @(posedge ref_clk) disable iff (!rst_b)
        (state == ftx_pkg::ST_HOLD && tmr != 24'h000000)
            |=> state == ftx_pkg::ST_HOLD && !waiting_for_trigger;
    endproperty
    a_hold_min: assert property (p_hold_min)
        else $error("width mode ready before programmed time");

    property p_src_default;
        @(posedge ref_clk) disable iff (!rst_b)
        $rose(rst_b) |-> src == ftx_pkg::SRC_LINE1;
    endproperty
    a_src_default: assert property (p_src_default)
        else $error("source not first line after reset");

    property p_edge_once;
        @(posedge ref_clk) disable iff (!rst_b)
        hw_edge && $stable(ctrl) |=> !hw_edge || $changed(ctrl);
    endproperty
    a_edge_once: assert property (p_edge_once)
        else $error("edge detected twice");
endmodule : ftx_trigger_ctrl

`default_nettype wire

/* rtl/ftx_pkg.sv */
// ftx_pkg: constants for the frame trigger and exposure controller.
// assumes a single 125 MHz clock and an AXI4-Lite register port.
package ftx_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int NS_PER_US = 1000;
    localparam int CYC_PER_US = NS_PER_US / CLK_PERIOD_NS;
    localparam int PRESC_W = 7;
    localparam int TIME_W = 24;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_EXPO = 8'h04;
    localparam logic [7:0] OFS_DELAY = 8'h08;
    localparam logic [7:0] OFS_CMD = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int CTRL_GATE = 0;
    localparam int CTRL_SRC_LO = 1;
    localparam int CTRL_SRC_HI = 2;
    localparam int CTRL_POL = 3;
    localparam int CTRL_KIND = 4;
    localparam int CTRL_W = 5;
    localparam logic [1:0] SRC_LINE1 = 2'h0;
    localparam logic [1:0] SRC_LINE2 = 2'h1;
    localparam logic [1:0] SRC_HOST = 2'h2;
    localparam logic [4:0] CTRL_RESET = 5'h00;
    localparam logic [23:0] EXPO_RESET = 24'h000064;
    localparam logic [23:0] DELAY_RESET = 24'h000000;
    localparam int IRQ_OVER = 0;
    localparam int IRQ_START = 1;
    localparam int IRQ_END = 2;
    localparam int IRQ_W = 3;
    localparam logic [2:0] IRQ_RESET = 3'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_WAIT,
        ST_DELAY,
        ST_TIMED,
        ST_WIDTH,
        ST_HOLD
    } ftx_state_type;
endpackage : ftx_pkg

/* sim/ftx_trig_src.sv */
// ftx_trig_src: external source driving the two trigger lines.
// assumes the bench calls its tasks just after a ref_clk edge.
`timescale 1ns/10ps
`default_nettype none
module ftx_trig_src (
    input wire logic ref_clk,
    output logic [1:0] line
);
    // ------------------------------------------------------------
    // line drive
    // ------------------------------------------------------------
    initial begin
        line = 2'h0;
    end
    task automatic hold(input int idx, input logic v, input int n);
        @(posedge ref_clk);
        line[idx] <= v;
        repeat (n) @(posedge ref_clk);
    endtask : hold
    // callers keep n well above the two-stage synchroniser delay
    task automatic pulse(input int idx, input int n);
        hold(idx, !line[idx], n);
        hold(idx, !line[idx], 2);
    endtask : pulse
endmodule : ftx_trig_src
`default_nettype wire

/* sim/test_ftx_trigger_ctrl.sv */
// test_ftx_trigger_ctrl: self-checking bench for the trigger controller.
// assumes a 125 MHz clock; exposure counts run at full length.
`timescale 1ns/10ps
`default_nettype none
module test_ftx_trigger_ctrl;
    logic ref_clk, rst_b;
    logic [1:0] trig;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_val;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic exposure_active, waiting_for_trigger, frame_start, irq;
    int err_count, checks, starts, lat, len, w, n0;
    ftx_trig_src ftx_trig_src_i (.ref_clk(ref_clk), .line(trig));
    ftx_trigger_ctrl ftx_trigger_ctrl_i (.ref_clk, .rst_b,
        .ext_frame_trigger_in(trig), .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .exposure_active,
        .waiting_for_trigger, .frame_start, .irq);
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) if (frame_start === 1'b1) starts <= starts + 1;
    // ------------------------------------------------------------
    // bus and check tasks
    // ------------------------------------------------------------
    task automatic print_verdict;
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict
    task automatic tmo;
        err_count++;
        $display("MISMATCH t=%0t wait limit got=%h exp=%h", $time, 0, 1);
        print_verdict();
    endtask : tmo
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [2:0] p;
        int n;
        // one idle edge so bready is never lowered and raised at once
        @(posedge ref_clk);
        p = 3'h7;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (p != 3'h0) begin
            @(posedge ref_clk);
            n++;
            if (s_axi_awready && p[0]) s_axi_awvalid <= 1'b0;
            if (s_axi_wready && p[1]) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && p[2]) s_axi_bready <= 1'b0;
            if (s_axi_bvalid && p[2]) wr_resp = s_axi_bresp;
            p = p & ~{s_axi_bvalid, s_axi_wready, s_axi_awready};
            if (n > 50) tmo();
        end
    endtask : wr
    task automatic rd(input logic [7:0] a);
        logic [1:0] p;
        int n;
        @(posedge ref_clk);
        p = 2'h3;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (p != 2'h0) begin
            @(posedge ref_clk);
            n++;
            if (s_axi_arready && p[0]) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && p[1]) s_axi_rready <= 1'b0;
            if (s_axi_rvalid && p[1]) rd_val = s_axi_rdata;
            if (s_axi_rvalid && p[1]) rd_resp = s_axi_rresp;
            p = p & ~{s_axi_rvalid, s_axi_arready};
            if (n > 50) tmo();
        end
    endtask : rd
    // latency, exposure length and the wait until ready again
    task automatic run_frame;
        lat = 0;
        len = 0;
        w = 0;
        while (exposure_active !== 1'b1) begin
            @(posedge ref_clk);
            lat++;
            if (lat > 2000) tmo();
        end
        chk(waiting_for_trigger, 1'b0);
        while (exposure_active === 1'b1) begin
            @(posedge ref_clk);
            len++;
            if (len > 4000) tmo();
        end
        while (waiting_for_trigger !== 1'b1) begin
            @(posedge ref_clk);
            w++;
            if (w > 2000) tmo();
        end
    endtask : run_frame
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        chk(waiting_for_trigger, 1'b1);
        rd(ftx_pkg::OFS_CTRL);
        chk(rd_val, 32'h0);
        rd(ftx_pkg::OFS_EXPO);
        chk(rd_val, {8'h00, ftx_pkg::EXPO_RESET});
        rd(ftx_pkg::OFS_STATUS);
        chk(rd_val, 32'h1);
        rd(8'h40);
        chk(rd_resp, ftx_pkg::RESP_SLVERR);
        wr(8'h40, 32'h1);
        chk(wr_resp, ftx_pkg::RESP_SLVERR);
    endtask : t_reset
    task automatic t_timed;
        wr(ftx_pkg::OFS_EXPO, 32'h2);
        wr(ftx_pkg::OFS_IRQ_MASK, 32'h1);
        wr(ftx_pkg::OFS_CTRL, 32'h1);
        n0 = starts;
        fork
            begin
                ftx_trig_src_i.pulse(0, 20);
                repeat (60) @(posedge ref_clk);
                ftx_trig_src_i.pulse(0, 20);
            end
            run_frame();
        join
        chk(lat inside {[2:8]}, 1);
        chk(len inside {[249:251]}, 1);
        chk(starts - n0, 1);
        chk(irq, 1'b1);
        rd(ftx_pkg::OFS_IRQ_STAT);
        chk(rd_val, 32'h7);
        wr(ftx_pkg::OFS_IRQ_STAT, 32'h1);
        repeat (2) @(posedge ref_clk);
        chk(irq, 1'b0);
    endtask : t_timed
    task automatic t_fall;
        wr(ftx_pkg::OFS_CTRL, 32'h0);
        ftx_trig_src_i.hold(1, 1'b1, 4);
        wr(ftx_pkg::OFS_CTRL, 32'h0b);
        n0 = starts;
        fork
            ftx_trig_src_i.pulse(1, 20);
            run_frame();
        join
        chk(lat inside {[2:8]}, 1);
        chk(len inside {[249:251]}, 1);
        chk(starts - n0, 1);
    endtask : t_fall
    task automatic t_width;
        wr(ftx_pkg::OFS_CTRL, 32'h11);
        fork
            ftx_trig_src_i.pulse(0, 400);
            run_frame();
        join
        chk(len inside {[397:403]}, 1);
        fork
            ftx_trig_src_i.pulse(0, 100);
            run_frame();
        join
        chk(len inside {[97:103]}, 1);
        chk((len + w) inside {[248:256]}, 1);
        wr(ftx_pkg::OFS_CTRL, 32'h0);
        ftx_trig_src_i.hold(0, 1'b1, 4);
        wr(ftx_pkg::OFS_CTRL, 32'h19);
        fork
            ftx_trig_src_i.pulse(0, 300);
            run_frame();
        join
        chk(len inside {[297:303]}, 1);
    endtask : t_width
    task automatic t_delay;
        wr(ftx_pkg::OFS_CTRL, 32'h0);
        ftx_trig_src_i.hold(0, 1'b0, 4);
        wr(ftx_pkg::OFS_DELAY, 32'h1);
        wr(ftx_pkg::OFS_CTRL, 32'h1);
        fork
            ftx_trig_src_i.pulse(0, 20);
            run_frame();
        join
        chk(lat inside {[126:134]}, 1);
        wr(ftx_pkg::OFS_CTRL, 32'h15);
        fork
            wr(ftx_pkg::OFS_CMD, 32'h1);
            run_frame();
        join
        chk(lat inside {[1:8]}, 1);
        chk(len inside {[249:251]}, 1);
    endtask : t_delay
    initial begin
        rst_b = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        s_axi_wstrb = 4'hf;
        err_count = 0;
        checks = 0;
        starts = 0;
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge ref_clk);
        t_reset();
        t_timed();
        t_fall();
        t_width();
        t_delay();
        print_verdict();
    end
endmodule : test_ftx_trigger_ctrl
`default_nettype wire
